// ==== src/adsm_regs.svh ====
// Purpose: Register offsets, field positions, reset values and timing counts.
// Assumes: AHB-Lite slave with 32-bit data, one register per aligned word.
// Notes: Definitions only.
`ifndef ADSM_REGS_SVH
`define ADSM_REGS_SVH
`define ADSM_OFF_CTRL 12'h000
`define ADSM_OFF_ACCLIM 12'h004
`define ADSM_OFF_RESP 12'h008
`define ADSM_OFF_JITTER 12'h00C
`define ADSM_OFF_STATUS 12'h010
`define ADSM_OFF_CLEAR 12'h014
`define ADSM_OFF_ACCEL 12'h018
`define ADSM_CTRL_CFGVALID 0
`define ADSM_CTRL_ACCEN 1
`define ADSM_CTRL_ACCSTO 2
`define ADSM_CTRL_DIRLO 4
`define ADSM_CTRL_DIRHI 6
`define ADSM_CTRL_ENC1NEG 8
`define ADSM_CTRL_ENC2NEG 9
`define ADSM_CTRL_HIFREQ 10
`define ADSM_CTRL_RESET 32'h0000_0004
`define ADSM_ACCLIM_RESET 16'h0000
`define ADSM_RESP_RESET 16'h0064
`define ADSM_JITTER_RESET 16'h0000
`define ADSM_RESP_OFFSET_MS 16'h0024
`define ADSM_CLK_HZ 25000000
`define ADSM_CYC_PER_MS (`ADSM_CLK_HZ / 1000)
`endif

// ==== src/adsm_pkg.sv ====
// Purpose: Shared types of the acceleration and direction safety monitor.
// Assumes: Included constants come from adsm_regs.svh.
// Notes: Types only.
package adsm_pkg;
  typedef enum logic [2:0] {
    DIR_OFF, DIR_POS_ALWAYS, DIR_NEG_ALWAYS, DIR_POS_LIMITED, DIR_NEG_LIMITED
  } adsm_dirmode_t;
  typedef enum logic [1:0] {
    STOP_NONE, STOP_DELAY, STOP_MAXTIME
  } adsm_phase_t;
endpackage

// ==== src/adsm_if.sv ====
// Purpose: Carries encoder counts between the main monitor and its tracker.
// Assumes: Both modules run on clk_sys.
// Notes: One driver per modport side.
`timescale 1ns/1ps
`default_nettype none
interface adsm_if;
  logic signed [31:0] enc1Pos;
  logic signed [31:0] enc2Pos;
  logic enc1Neg;
  logic enc2Neg;
  logic signed [31:0] dirPos;
  modport monitor(output enc1Pos, output enc2Pos, output enc1Neg, output enc2Neg, input dirPos);
  modport tracker(input enc1Pos, input enc2Pos, input enc1Neg, input enc2Neg, output dirPos);
endinterface
`default_nettype wire

// ==== src/adsm_pos_track.sv ====
// Purpose: Applies polarity to encoder 1 and forms the signed position used for direction checks.
// Assumes: Encoder counts are already synchronous to clk_sys.
// Notes: Encoder 2 polarity is carried for completeness; encoder 1 is the reference axis.
`timescale 1ns/1ps
`default_nettype none
module adsm_pos_track
  import adsm_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Encoder link.
  adsm_if.tracker link
);
  logic signed [31:0] pos_r;
  logic signed [31:0] pos_nxt;

  always_comb begin
    pos_nxt = link.enc1Neg ? -link.enc1Pos : link.enc1Pos;
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pos_r <= 32'sh0000_0000;
    end else begin
      pos_r <= pos_nxt;
    end
  end

  assign link.dirPos = pos_r;
endmodule
`default_nettype wire

// ==== src/adsm_monitor.sv ====
// Purpose: Acceleration and direction safety monitor with an AHB-Lite register file.
// Assumes: Encoder counts arrive as parallel words from another clock domain.
// Notes on behaviour
// - Accel check active: enabled, valid, mode on.
// - Window is response time minus 36 ms.
// - Fault when acceleration reaches the limit.
// - Stop behaviour selects torque-off or stop category.
// - Fault in monitor delay starts maximum stop time; code pulses endStopDelay only when torque-off is selected.
// - Configured stop, low frequency: only report; code does so only while maxStopActive, else requests the stop category.
// - Torque-off during stop time: remove power, standstill.
// - Wrong direction starts configured stop category.
// - Five direction modes; limited-speed modes gated.
// - Always modes active when valid and not disabled.
// - Fault once wrong travel exceeds jitter tolerance.
// - Direction fault stops, suspends direction checks.
// - Late direction fault forces all outputs faulted.
// - Accel limit relative to encoder 1, default zero.
// - Stop behaviour defaults to torque-off.
//
// Our own choices: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "adsm_regs.svh"
module adsm_monitor
  import adsm_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic sys_rst,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Encoder feedback and drive state.
  input wire logic [31:0] enc1Count,
  input wire logic [31:0] enc2Count,
  input wire logic modeEnabled,
  input wire logic limited_speed_monitor,
  input wire logic stopDelayActive,
  input wire logic maxStopActive,
  // Fault reactions.
  output logic accelFault,
  output logic dirFault,
  output logic reqTorqueOff,
  output logic reqStopCat,
  output logic endStopDelay,
  output logic standstillCheck,
  output logic allFaulted
);
  adsm_if link();
  adsm_pos_track posTrack (.clk_sys(clk_sys), .sys_rst(sys_rst), .link(link));

  // Pin synchroniser: three stages, a change counts once stages two and three agree.
  logic [31:0] e1s1_r, e1s2_r, e1s3_r, e1_r;
  logic [31:0] e2s1_r, e2s2_r, e2s3_r, e2_r;
  logic [31:0] e1_nxt, e2_nxt;
  always_comb begin
    e1_nxt = (e1s2_r == e1s3_r) ? e1s3_r : e1_r;
    e2_nxt = (e2s2_r == e2s3_r) ? e2s3_r : e2_r;
  end
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      e1s1_r <= 32'h0000_0000;
      e1s2_r <= 32'h0000_0000;
      e1s3_r <= 32'h0000_0000;
      e1_r <= 32'h0000_0000;
      e2s1_r <= 32'h0000_0000;
      e2s2_r <= 32'h0000_0000;
      e2s3_r <= 32'h0000_0000;
      e2_r <= 32'h0000_0000;
    end else begin
      e1s1_r <= enc1Count;
      e1s2_r <= e1s1_r;
      e1s3_r <= e1s2_r;
      e1_r <= e1_nxt;
      e2s1_r <= enc2Count;
      e2s2_r <= e2s1_r;
      e2s3_r <= e2s2_r;
      e2_r <= e2_nxt;
    end
  end

  // Registers.
  logic [31:0] ctrl_r, ctrl_nxt;
  logic [15:0] accLim_r, accLim_nxt;
  logic [15:0] resp_r, resp_nxt;
  logic [15:0] jitter_r, jitter_nxt;
  logic wrPend_r, wrPend_nxt;
  logic [11:0] wrAddr_r, wrAddr_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic clrAcc, clrDir;

  assign link.enc1Pos = e1_r;
  assign link.enc2Pos = e2_r;
  assign link.enc1Neg = ctrl_r[`ADSM_CTRL_ENC1NEG];
  assign link.enc2Neg = ctrl_r[`ADSM_CTRL_ENC2NEG];

  // Monitor state.
  logic cfgValid;
  logic accActive;
  logic dirActive;
  adsm_dirmode_t dirMode;
  logic [31:0] winCnt_r, winCnt_nxt;
  logic signed [31:0] lastPos_r, lastPos_nxt;
  logic signed [31:0] lastVel_r, lastVel_nxt;
  logic signed [31:0] accel_r, accel_nxt;
  logic primed_r, primed_nxt;
  logic signed [31:0] anchor_r, anchor_nxt;
  logic accF_r, accF_nxt;
  logic dirF_r, dirF_nxt;
  logic sto_r, sto_nxt;
  logic stopCat_r, stopCat_nxt;
  logic endDly_r, endDly_nxt;
  logic stand_r, stand_nxt;
  logic allF_r, allF_nxt;
  logic dirSusp_r, dirSusp_nxt;
  logic [31:0] winLen;
  logic signed [31:0] vel, dAcc, wrongTravel;
  logic accTrip, dirTrip, stopping;

  function automatic logic [31:0] absVal(input logic signed [31:0] v);
    absVal = v[31] ? 32'(-v) : 32'(v);
  endfunction

  function automatic logic [31:0] windowCycles(input logic [15:0] respMs);
    logic [15:0] ms;
    ms = (respMs > `ADSM_RESP_OFFSET_MS) ? 16'(respMs - `ADSM_RESP_OFFSET_MS) : 16'h0001;
    windowCycles = 32'(ms) * 32'(`ADSM_CYC_PER_MS);
  endfunction

  always_comb begin
    cfgValid = ctrl_r[`ADSM_CTRL_CFGVALID];
    dirMode = adsm_dirmode_t'(ctrl_r[`ADSM_CTRL_DIRHI:`ADSM_CTRL_DIRLO]);
    accActive = ctrl_r[`ADSM_CTRL_ACCEN] && cfgValid && modeEnabled;
    case (dirMode)
      DIR_POS_ALWAYS, DIR_NEG_ALWAYS: dirActive = cfgValid && modeEnabled;
      DIR_POS_LIMITED, DIR_NEG_LIMITED: dirActive = cfgValid && modeEnabled && limited_speed_monitor;
      default: dirActive = 1'b0;
    endcase
    stopping = stopDelayActive || maxStopActive;
    winLen = windowCycles(resp_r);
    vel = link.dirPos - lastPos_r;
    dAcc = vel - lastVel_r;
    winCnt_nxt = winCnt_r + 32'h0000_0001;
    lastPos_nxt = lastPos_r;
    lastVel_nxt = lastVel_r;
    accel_nxt = accel_r;
    primed_nxt = primed_r;
    accTrip = 1'b0;
    if (winCnt_r >= winLen - 32'h0000_0001) begin
      winCnt_nxt = 32'h0000_0000;
      lastPos_nxt = link.dirPos;
      lastVel_nxt = vel;
      primed_nxt = 1'b1;
      if (primed_r) begin
        accel_nxt = dAcc;
        accTrip = accActive && (absVal(dAcc) >= 32'(accLim_r));
      end
    end
    if (!dirActive || dirSusp_r) begin
      anchor_nxt = link.dirPos;
    end else if (dirMode == DIR_POS_ALWAYS || dirMode == DIR_POS_LIMITED) begin
      anchor_nxt = (link.dirPos > anchor_r) ? link.dirPos : anchor_r;
    end else begin
      anchor_nxt = (link.dirPos < anchor_r) ? link.dirPos : anchor_r;
    end
    wrongTravel = anchor_nxt - link.dirPos;
    dirTrip = dirActive && !dirSusp_r &&
      (absVal(wrongTravel) > 32'(jitter_r));
    accF_nxt = accTrip || (accF_r && !clrAcc);
    dirF_nxt = dirTrip || (dirF_r && !clrDir);
    // Own stop requests hold until the stop has run and the fault is cleared.
    sto_nxt = sto_r && (stopping || accF_r);
    stopCat_nxt = stopCat_r && (stopping || accF_r || dirF_r);
    stand_nxt = stand_r && stopping;
    endDly_nxt = 1'b0;
    dirSusp_nxt = dirSusp_r && (stopping || dirF_r);
    allF_nxt = allF_r;
    if (accTrip) begin
      if (ctrl_r[`ADSM_CTRL_ACCSTO]) begin
        sto_nxt = 1'b1;
        if (stopDelayActive) begin
          endDly_nxt = 1'b1;
        end
        if (maxStopActive) begin
          stand_nxt = 1'b1;
        end
      end else if (!maxStopActive || ctrl_r[`ADSM_CTRL_HIFREQ]) begin
        stopCat_nxt = 1'b1;
      end
    end
    if (dirTrip) begin
      if (stopping) begin
        allF_nxt = 1'b1;
      end else begin
        stopCat_nxt = 1'b1;
        dirSusp_nxt = 1'b1;
      end
    end
    if (allF_nxt) begin
      sto_nxt = 1'b1;
      stopCat_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      winCnt_r <= 32'h0000_0000;
      lastPos_r <= 32'sh0000_0000;
      lastVel_r <= 32'sh0000_0000;
      accel_r <= 32'sh0000_0000;
      primed_r <= 1'b0;
      anchor_r <= 32'sh0000_0000;
      accF_r <= 1'b0;
      dirF_r <= 1'b0;
      sto_r <= 1'b0;
      stopCat_r <= 1'b0;
      endDly_r <= 1'b0;
      stand_r <= 1'b0;
      allF_r <= 1'b0;
      dirSusp_r <= 1'b0;
    end else begin
      winCnt_r <= winCnt_nxt;
      lastPos_r <= lastPos_nxt;
      lastVel_r <= lastVel_nxt;
      accel_r <= accel_nxt;
      primed_r <= primed_nxt;
      anchor_r <= anchor_nxt;
      accF_r <= accF_nxt;
      dirF_r <= dirF_nxt;
      sto_r <= sto_nxt;
      stopCat_r <= stopCat_nxt;
      endDly_r <= endDly_nxt;
      stand_r <= stand_nxt;
      allF_r <= allF_nxt;
      dirSusp_r <= dirSusp_nxt;
    end
  end

  // AHB-Lite slave: zero wait states, writes land at the end of the data phase.
  logic take;
  always_comb begin
    take = hsel && htrans[1] && hready;
    ctrl_nxt = ctrl_r;
    accLim_nxt = accLim_r;
    resp_nxt = resp_r;
    jitter_nxt = jitter_r;
    clrAcc = 1'b0;
    clrDir = 1'b0;
    if (wrPend_r) begin
      case (wrAddr_r)
        `ADSM_OFF_CTRL: ctrl_nxt = hwdata & 32'h0000_0777;
        `ADSM_OFF_ACCLIM: accLim_nxt = hwdata[15:0];
        `ADSM_OFF_RESP: resp_nxt = hwdata[15:0];
        `ADSM_OFF_JITTER: jitter_nxt = hwdata[15:0];
        `ADSM_OFF_CLEAR: begin
          clrAcc = hwdata[0];
          clrDir = hwdata[1];
        end
        default: ;
      endcase
    end
    wrPend_nxt = take && hwrite;
    wrAddr_nxt = take ? haddr : wrAddr_r;
    rdata_nxt = 32'h0000_0000;
    if (take && !hwrite) begin
      case (haddr)
        `ADSM_OFF_CTRL: rdata_nxt = ctrl_r;
        `ADSM_OFF_ACCLIM: rdata_nxt = {16'h0000, accLim_r};
        `ADSM_OFF_RESP: rdata_nxt = {16'h0000, resp_r};
        `ADSM_OFF_JITTER: rdata_nxt = {16'h0000, jitter_r};
        `ADSM_OFF_STATUS: rdata_nxt = {25'h0, dirSusp_r, allF_r, stand_r, stopCat_r,
          sto_r, dirF_r, accF_r};
        `ADSM_OFF_ACCEL: rdata_nxt = accel_r;
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_r <= `ADSM_CTRL_RESET;
      accLim_r <= `ADSM_ACCLIM_RESET;
      resp_r <= `ADSM_RESP_RESET;
      jitter_r <= `ADSM_JITTER_RESET;
      wrPend_r <= 1'b0;
      wrAddr_r <= 12'h000;
      rdata_r <= 32'h0000_0000;
    end else begin
      ctrl_r <= ctrl_nxt;
      accLim_r <= accLim_nxt;
      resp_r <= resp_nxt;
      jitter_r <= jitter_nxt;
      wrPend_r <= wrPend_nxt;
      wrAddr_r <= wrAddr_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign hrdata = rdata_r;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign accelFault = accF_r;
  assign dirFault = dirF_r;
  assign reqTorqueOff = sto_r;
  assign reqStopCat = stopCat_r;
  assign endStopDelay = endDly_r;
  assign standstillCheck = stand_r;
  assign allFaulted = allF_r;
endmodule
`default_nettype wire

// ==== testbench/adsm_enc_model.sv ====
// Purpose: Encoder pair that follows a velocity command.
// Assumes: Velocity is in counts per update; counts update every second clk_sys cycle.
// Notes: Counts sit at zero while the monitor is in reset.
`timescale 1ns/1ps
`default_nettype none
module adsm_enc_model (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Motion command.
  input wire logic signed [31:0] stepVel,
  input wire logic rampOn,
  // Encoder counts.
  output logic [31:0] enc1Count,
  output logic [31:0] enc2Count
);
  logic signed [31:0] vel = 32'sh0;
  logic tick = 1'b0;
  // Each count stands two cycles so the monitor's agreement filter accepts it.
  always @(posedge clk_sys) begin
    tick <= ~tick;
    if (sys_rst) begin
      vel <= 32'sh0;
      enc1Count <= 32'h0;
    end else if (tick) begin
      vel <= rampOn ? vel + 32'sh1 : stepVel;
      enc1Count <= enc1Count + vel;
    end
  end
  // Both encoders report the same direction of motion.
  assign enc2Count = enc1Count;
endmodule
`default_nettype wire

// ==== testbench/adsm_properties.sv ====
// Purpose: Assertions on the monitor's fault reactions.
// Assumes: Sees only the adsm_monitor ports.
// Notes: Bound into every adsm_monitor instance.
`timescale 1ns/1ps
`default_nettype none
module adsm_properties (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Drive state.
  input wire logic modeEnabled,
  input wire logic stopDelayActive,
  input wire logic maxStopActive,
  // Reactions.
  input wire logic accelFault,
  input wire logic dirFault,
  input wire logic reqTorqueOff,
  input wire logic reqStopCat,
  input wire logic endStopDelay,
  input wire logic standstillCheck,
  input wire logic allFaulted
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  sequence s_pulse_end;
    ##1 (!endStopDelay && accelFault);
  endsequence
  sequence s_late_dir;
    $rose(dirFault) && $past(stopDelayActive || maxStopActive);
  endsequence
  a_all_latched: assert property (allFaulted |=> allFaulted)
    else $error("all-faulted dropped");
  a_all_forces: assert property (
    allFaulted |-> ##[0:1] (reqTorqueOff && reqStopCat))
    else $error("all-faulted without stops");
  a_late_dir: assert property (s_late_dir |-> ##[0:2] allFaulted)
    else $error("late direction fault kept");
  a_end_pulse: assert property (
    endStopDelay |-> $past(stopDelayActive) ##0 s_pulse_end)
    else $error("bad delay end pulse");
  a_sto_cause: assert property (
    $rose(reqTorqueOff) && !allFaulted |-> ##[0:1] accelFault)
    else $error("torque off without cause");
  a_stop_cause: assert property (
    $rose(reqStopCat) && !allFaulted |-> ##[0:1] (accelFault || dirFault))
    else $error("stop without cause");
  a_stand_sto: assert property (standstillCheck |-> ##[0:1] reqTorqueOff)
    else $error("standstill without torque off");
  a_accel_mode: assert property ($rose(accelFault) |-> $past(modeEnabled))
    else $error("fault while mode disabled");
endmodule
bind adsm_monitor adsm_properties i_adsm_properties (.clk_sys, .sys_rst, .modeEnabled,
  .stopDelayActive, .maxStopActive, .accelFault, .dirFault, .reqTorqueOff, .reqStopCat,
  .endStopDelay, .standstillCheck, .allFaulted);
`default_nettype wire

// ==== testbench/testbench.sv ====
// Purpose: Self-checking bench for the safety monitor.
// Assumes: Register offsets from adsm_regs.svh.
// Notes: A 37 ms response time gives 25000-cycle windows.
`timescale 1ns/1ps
`default_nettype none
`include "adsm_regs.svh"
module testbench;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] lfsr = 32'hD6ED;
  logic [31:0] hrdata, enc1Count, enc2Count, rd;
  logic hreadyout, hresp, accelFault, dirFault, reqTorqueOff, reqStopCat;
  logic endStopDelay, standstillCheck, allFaulted, expF, sawEnd;
  logic modeEnabled = 1'b1;
  logic limited_speed_monitor = 1'b0;
  logic stopDelayActive = 1'b0;
  logic maxStopActive = 1'b0;
  logic rampOn = 1'b0;
  logic signed [31:0] stepVel = 32'sh0;
  logic signed [31:0] wrongV;
  logic [15:0] dirCases[$] = '{16'h010A, 16'h010B, 16'h020B, 16'h0314, 16'h1314,
    16'h1414, 16'h0014, 16'h8114, 16'h210B};
  logic [2:0] m;
  int miscompares = 0;
  int cmp_count = 0;
  int n;
  always #20 clk_sys = ~clk_sys;
  adsm_monitor i_adsm_monitor (.clk_sys, .sys_rst, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .enc1Count,
    .enc2Count, .modeEnabled, .limited_speed_monitor, .stopDelayActive, .maxStopActive,
    .accelFault, .dirFault, .reqTorqueOff, .reqStopCat, .endStopDelay, .standstillCheck,
    .allFaulted);
  adsm_enc_model i_adsm_enc_model (.clk_sys, .sys_rst, .stepVel, .rampOn, .enc1Count,
    .enc2Count);
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic results();
    $display("comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chkb(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask
  // A wait that used up its bound counts as a mismatch and ends the run.
  task automatic limit(input int lim);
    if (n >= lim) begin
      miscompares++;
      results();
    end
  endtask
  // Single AHB-Lite transfer; read data lands in rd.
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    n = 0;
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do begin
      @(posedge clk_sys);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do begin
      @(posedge clk_sys);
      n++;
    end while (hreadyout !== 1'b1 && n < 40);
    rd = hrdata;
    chkb(hresp, 1'b0);
    limit(40);
  endtask
  task automatic do_reset();
    sys_rst <= 1'b1;
    repeat (16) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic move(input logic signed [31:0] v, input int cyc);
    stepVel <= v;
    repeat (2 * cyc) @(posedge clk_sys);
    stepVel <= 32'sh0;
    repeat (12) @(posedge clk_sys);
  endtask
  initial begin
    do_reset();
    bus(1'b0, `ADSM_OFF_CTRL, 32'h0);
    chk(rd, 32'h4);
    bus(1'b0, `ADSM_OFF_ACCLIM, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, 12'h01C, 32'h0);
    chk(rd, 32'h0);
    repeat (4) begin
      lfsr = lfsr_next(lfsr);
      bus(1'b1, `ADSM_OFF_ACCLIM, {16'h0, lfsr[15:0]});
      bus(1'b0, `ADSM_OFF_ACCLIM, 32'h0);
      chk(rd, {16'h0, lfsr[15:0]});
    end
    $display("register test done");
    foreach (dirCases[i]) begin
      m = dirCases[i][10:8];
      expF = (m == 3'h1 || m == 3'h2 || (m > 3'h2 && dirCases[i][12]))
        && dirCases[i][7:0] > 8'hA && !dirCases[i][13];
      wrongV = (m == 3'h1 || m == 3'h3) ? -32'sh1 : 32'sh1;
      do_reset();
      modeEnabled <= !dirCases[i][13];
      limited_speed_monitor <= dirCases[i][12];
      stopDelayActive <= dirCases[i][15];
      bus(1'b1, `ADSM_OFF_JITTER, 32'hA);
      bus(1'b1, `ADSM_OFF_CTRL, {25'h0, m, 4'h1});
      repeat (8) @(posedge clk_sys);
      move(wrongV, dirCases[i][7:0]);
      chkb(dirFault, expF);
      chkb(allFaulted, expF & dirCases[i][15]);
      if (expF && !dirCases[i][15]) begin
        stopDelayActive <= 1'b1;
        move(wrongV, 20);
        chkb(reqStopCat, 1'b1);
        chkb(allFaulted, 1'b0);
      end
      stopDelayActive <= 1'b0;
      limited_speed_monitor <= 1'b0;
      modeEnabled <= 1'b1;
    end
    $display("direction test done");
    do_reset();
    stopDelayActive <= 1'b1;
    bus(1'b1, `ADSM_OFF_RESP, 32'h25);
    bus(1'b1, `ADSM_OFF_ACCLIM, 32'h64);
    bus(1'b1, `ADSM_OFF_CTRL, 32'h7);
    rampOn <= 1'b1;
    sawEnd = 1'b0;
    for (n = 0; n < 60000 && accelFault !== 1'b1; n++) begin
      @(posedge clk_sys);
      sawEnd = sawEnd | endStopDelay;
    end
    limit(60000);
    @(posedge clk_sys);
    chkb(accelFault, 1'b1);
    chkb(reqTorqueOff, 1'b1);
    chkb(sawEnd | endStopDelay, 1'b1);
    stopDelayActive <= 1'b0;
    maxStopActive <= 1'b1;
    for (n = 0; n < 30000 && standstillCheck !== 1'b1; n++) begin
      @(posedge clk_sys);
    end
    limit(30000);
    chkb(standstillCheck, 1'b1);
    chkb(reqTorqueOff, 1'b1);
    bus(1'b1, `ADSM_OFF_CTRL, 32'h3);
    bus(1'b1, `ADSM_OFF_CLEAR, 32'h1);
    @(posedge clk_sys);
    chkb(accelFault, 1'b0);
    for (n = 0; n < 30000 && accelFault !== 1'b1; n++) begin
      @(posedge clk_sys);
    end
    limit(30000);
    @(posedge clk_sys);
    chkb(accelFault, 1'b1);
    chkb(reqStopCat, 1'b0);
    rampOn <= 1'b0;
    $display("acceleration test done");
    results();
  end
endmodule
`default_nettype wire
